/* File: hw/spdr_lock_detect.sv */
`timescale 1ns/1ps
module spdr_lock_detect
   import spdr_pkg::*;
(
   // Clock and reset
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   // Control
   input  wire logic                 lock_detect_en,
   input  wire logic [1:0]           lock_window_length,
   // Loop observation
   input  wire logic                 ref_tick,
   input  wire logic                 phase_in_window,
   // Status
   output logic                      locked
);
   spdr_lock_state_t        state_q, state_d;
   logic [LOCK_CNT_W-1:0]   cnt_q, cnt_d;
   logic [LOCK_CNT_W-1:0]   limit;

   assign limit  = LOCK_WIN_BASE << lock_window_length;
   assign locked = (state_q == LD_LOCKED);

   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      case (state_q)
         LD_OFF: begin
            cnt_d = '0;
            if (lock_detect_en) begin
               state_d = LD_SEEK;
            end
         end
         LD_SEEK: begin
            if (ref_tick && !phase_in_window) begin
               cnt_d = '0;
            end else if (ref_tick) begin
               cnt_d = cnt_q + 1'b1;
               if (cnt_d == limit) begin
                  state_d = LD_LOCKED;
               end
            end
         end
         LD_LOCKED: begin
            // A single reference tick outside the window drops lock and restarts the count.
            if (ref_tick && !phase_in_window) begin
               state_d = LD_SEEK;
               cnt_d   = '0;
            end
         end
         default: begin
            state_d = LD_OFF;
            cnt_d   = '0;
         end
      endcase
      if (!lock_detect_en) begin
         state_d = LD_OFF;
         cnt_d   = '0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= LD_OFF;
         cnt_q   <= '0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
      end
   end
endmodule : spdr_lock_detect

/* File: hw/spdr_regs.sv */
// Behaviour
// - Doubler circuit runs when edge bit 16 and doubler enable bit 19 are both set.
// - Bits 15..8 hold feedback divider N; total multiplication is twice N.
// - Feedback divider resets to 25, giving default multiplication of 50.
// - Bit 6 clear uses calibrated pump current; set uses manual code.
// - Bits 5..3 give the manual charge pump current code.
// - Bit 2 enables lock detection of the multiplier loop.
// - Bits 1..0 choose lock window of 128, 256, 512 or 1024 reference cycles.
// - Lock status reads back at bit 24 of register 0x00.
// - DAC word bit 26 set powers down the sync output circuitry.
// - Bit 25 powers down calibration clock; it runs only if bits 25, 26 clear.
// - Writing one to DAC word bit 24 starts automatic DAC calibration.
// - Ramp limits and step act only while ramp enable 0x01 bit 19 is set.
// - Register 0x04 holds the 32-bit ramp lower limit.
// - Register 0x05 holds the 32-bit ramp upper limit.
// - Register 0x06 holds the 32-bit rising ramp step.
`timescale 1ns/1ps
module spdr_regs
   import spdr_pkg::*;
(
   // Clock and reset
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   // APB slave
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [ADDR_W-1:0]    paddr,
   input  wire logic [31:0]          pwdata,
   output logic                      pready,
   output logic [31:0]               prdata,
   output logic                      pslverr,
   // Loop observation and calibration result
   input  wire logic                 ref_tick,
   input  wire logic                 phase_in_window,
   input  wire logic [2:0]           auto_pump_code,
   // Multiplier loop controls
   output logic                      doubler_on,
   output logic [7:0]                feedback_div_n,
   output logic [8:0]                loop_mult_total,
   output logic [2:0]                pump_current_code,
   output logic                      lock_detect_en,
   output logic [1:0]                lock_window_length,
   output logic                      pll_locked,
   output logic                      osc_cal_start,
   // DAC controls
   output logic                      sync_out_pd,
   output logic                      dac_cal_clk_on,
   output logic                      dac_cal_start,
   // Ramp generator controls
   output logic                      ramp_enable,
   output logic [31:0]               ramp_lower,
   output logic [31:0]               ramp_upper,
   output logic [31:0]               ramp_rise_step
);
   // Stored register fields.
   logic                     ramp_en_q;
   logic                     dbl_en_q;
   logic                     dbl_edge_q;
   logic [7:0]               fb_n_q;
   logic                     man_pump_q;
   logic [2:0]               pump_code_q;
   logic                     lock_en_q;
   logic [1:0]               win_q;
   logic                     sync_pd_q;
   logic                     cal_clk_pd_q;
   logic [DC_KEEP_MSB:0]     dac_keep_q;
   logic [31:0]              ramp_low_q;
   logic [31:0]              ramp_high_q;
   logic [31:0]              ramp_rise_q;

   // Output flops.
   logic                     pready_q;
   logic [31:0]              prdata_q;
   logic                     pslverr_q;
   logic                     doubler_on_q;
   logic [8:0]               mult_total_q;
   logic [2:0]               pump_out_q;
   logic                     locked_q;
   logic                     osc_cal_q;
   logic                     dac_cal_q;
   logic                     cal_clk_on_q;
   logic [31:0]              ramp_low_out_q;
   logic [31:0]              ramp_high_out_q;
   logic [31:0]              ramp_rise_out_q;

   // Decoding and bus phases.
   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [3:0] idx);
      hit = (a[IDX_MSB:IDX_LSB] == idx) && (a[IDX_LSB-1:0] == '0) &&
            (a[ADDR_W-1:IDX_MSB+1] == '0);
   endfunction : hit

   wire        setup_ph  = psel && !penable;
   wire        wr_commit = psel && penable && pready_q && pwrite && !pslverr_q;
   wire        hit_first = hit(paddr, IDX_FIRST_CTRL);
   wire        hit_sec   = hit(paddr, IDX_SECOND_CTRL);
   wire        hit_cm    = hit(paddr, IDX_CLK_MULT);
   wire        hit_dac   = hit(paddr, IDX_DAC_CAL);
   wire        hit_low   = hit(paddr, IDX_RAMP_LOW);
   wire        hit_high  = hit(paddr, IDX_RAMP_HIGH);
   wire        hit_rise  = hit(paddr, IDX_RAMP_RISE);
   wire        mapped    = hit_first | hit_sec | hit_cm | hit_dac |
                           hit_low | hit_high | hit_rise;
   wire        lock_now;

   // Per-register write strobes of a committing access.
   wire        wr_first  = wr_commit && hit_first;
   wire        wr_sec    = wr_commit && hit_sec;
   wire        wr_cm     = wr_commit && hit_cm;
   wire        wr_dac    = wr_commit && hit_dac;
   wire        wr_low    = wr_commit && hit_low;
   wire        wr_high   = wr_commit && hit_high;
   wire        wr_rise   = wr_commit && hit_rise;

   // Read views; every bit not named here reads as zero.
   wire [31:0] rd_first  = 32'(locked_q) << FC_LOCK_BIT;
   wire [31:0] rd_sec    = 32'(ramp_en_q) << SC_RAMP_EN_BIT;
   wire [31:0] rd_cm     = (32'(dbl_en_q) << CM_DBL_EN_BIT) |
                           (32'(dbl_edge_q) << CM_DBL_EDGE_BIT) |
                           (32'(fb_n_q) << CM_N_LSB) |
                           (32'(man_pump_q) << CM_MAN_PUMP_BIT) |
                           (32'(pump_code_q) << CM_PUMP_LSB) |
                           (32'(lock_en_q) << CM_LOCK_EN_BIT) |
                           (32'(win_q) << CM_WIN_LSB);
   // The calibration start bit is a trigger and always reads back as zero.
   wire [31:0] rd_dac    = (32'(sync_pd_q) << DC_SYNC_PD_BIT) |
                           (32'(cal_clk_pd_q) << DC_CLK_PD_BIT) |
                           32'(dac_keep_q);
   wire [31:0] rd_mux    = hit_first ? rd_first :
                           hit_sec   ? rd_sec :
                           hit_cm    ? rd_cm :
                           hit_dac   ? rd_dac :
                           hit_low   ? ramp_low_q :
                           hit_high  ? ramp_high_q :
                           hit_rise  ? ramp_rise_q : 32'h00000000;

   // Next bus answer.
   wire        pslverr_d = setup_ph && !mapped;
   wire [31:0] prdata_d  = (setup_ph && !pwrite) ? rd_mux : 32'h00000000;

   // Bus answer: data and status are prepared in the setup cycle so the
   // access cycle always completes with no wait states.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         prdata_q  <= 32'h00000000;
         pslverr_q <= 1'b0;
      end else begin
         pready_q  <= setup_ph;
         pslverr_q <= pslverr_d;
         prdata_q  <= prdata_d;
      end
   end

   // Control registers; only the owned bit positions are stored.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ramp_en_q   <= 1'b0;
         dbl_en_q    <= 1'b0;
         dbl_edge_q  <= 1'b0;
         fb_n_q      <= CM_N_RESET;
         man_pump_q  <= 1'b0;
         pump_code_q <= 3'h0;
         lock_en_q   <= 1'b0;
         win_q       <= 2'h0;
      end else if (wr_sec) begin
         ramp_en_q   <= pwdata[SC_RAMP_EN_BIT];
      end else if (wr_cm) begin
         dbl_en_q    <= pwdata[CM_DBL_EN_BIT];
         dbl_edge_q  <= pwdata[CM_DBL_EDGE_BIT];
         fb_n_q      <= pwdata[CM_N_MSB:CM_N_LSB];
         man_pump_q  <= pwdata[CM_MAN_PUMP_BIT];
         pump_code_q <= pwdata[CM_PUMP_MSB:CM_PUMP_LSB];
         lock_en_q   <= pwdata[CM_LOCK_EN_BIT];
         win_q       <= pwdata[CM_WIN_MSB:CM_WIN_LSB];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_pd_q    <= 1'b0;
         cal_clk_pd_q <= 1'b0;
         dac_keep_q   <= DC_KEEP_RESET;
      end else if (wr_dac) begin
         sync_pd_q    <= pwdata[DC_SYNC_PD_BIT];
         cal_clk_pd_q <= pwdata[DC_CLK_PD_BIT];
         dac_keep_q   <= pwdata[DC_KEEP_MSB:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ramp_low_q  <= 32'h00000000;
         ramp_high_q <= 32'h00000000;
         ramp_rise_q <= 32'h00000000;
      end else begin
         if (wr_low) begin
            ramp_low_q <= pwdata;
         end
         if (wr_high) begin
            ramp_high_q <= pwdata;
         end
         if (wr_rise) begin
            ramp_rise_q <= pwdata;
         end
      end
   end

   spdr_lock_detect u_lock (
      .pclk               (pclk),
      .presetn            (presetn),
      .lock_detect_en     (lock_en_q),
      .lock_window_length (win_q),
      .ref_tick           (ref_tick),
      .phase_in_window    (phase_in_window),
      .locked             (lock_now)
   );

   // Next values of the derived controls.
   wire        doubler_on_d = dbl_edge_q && dbl_en_q;
   wire [8:0]  mult_total_d = {fb_n_q, 1'b0};
   wire [2:0]  pump_out_d   = man_pump_q ? pump_code_q : auto_pump_code;
   wire        dac_cal_d    = wr_dac && pwdata[DC_CAL_GO_BIT];
   wire        osc_cal_d    = wr_first && pwdata[FC_OSC_CAL_BIT];
   // A DAC write moves the clock gate on the same edge as the power-down bits, so
   // the calibration clock never runs while the sync circuitry is already off.
   wire        cal_clk_on_d = wr_dac ? !(pwdata[DC_CLK_PD_BIT] || pwdata[DC_SYNC_PD_BIT]) :
                                       !(cal_clk_pd_q || sync_pd_q);
   // Ramp settings are held at zero toward the generator while disabled.
   wire [31:0] ramp_low_d   = ramp_en_q ? ramp_low_q : 32'h00000000;
   wire [31:0] ramp_high_d  = ramp_en_q ? ramp_high_q : 32'h00000000;
   wire [31:0] ramp_rise_d  = ramp_en_q ? ramp_rise_q : 32'h00000000;

   // Loop controls, registered so every output leaves a flip-flop.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         doubler_on_q <= 1'b0;
         mult_total_q <= 9'h000;
         pump_out_q   <= 3'h0;
         locked_q     <= 1'b0;
      end else begin
         doubler_on_q <= doubler_on_d;
         mult_total_q <= mult_total_d;
         pump_out_q   <= pump_out_d;
         locked_q     <= lock_now;
      end
   end

   // Calibration clock gate.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cal_clk_on_q <= 1'b0;
      end else begin
         cal_clk_on_q <= cal_clk_on_d;
      end
   end

   // Ramp settings toward the generator.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ramp_low_out_q  <= 32'h00000000;
         ramp_high_out_q <= 32'h00000000;
         ramp_rise_out_q <= 32'h00000000;
      end else begin
         ramp_low_out_q  <= ramp_low_d;
         ramp_high_out_q <= ramp_high_d;
         ramp_rise_out_q <= ramp_rise_d;
      end
   end

   // Calibration triggers are one-cycle pulses on the committing write.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dac_cal_q <= 1'b0;
         osc_cal_q <= 1'b0;
      end else begin
         dac_cal_q <= dac_cal_d;
         osc_cal_q <= osc_cal_d;
      end
   end

   assign pready             = pready_q;
   assign prdata             = prdata_q;
   assign pslverr            = pslverr_q;
   assign doubler_on         = doubler_on_q;
   assign feedback_div_n     = fb_n_q;
   assign loop_mult_total    = mult_total_q;
   assign pump_current_code  = pump_out_q;
   assign lock_detect_en     = lock_en_q;
   assign lock_window_length = win_q;
   assign pll_locked         = locked_q;
   assign osc_cal_start      = osc_cal_q;
   assign sync_out_pd        = sync_pd_q;
   assign dac_cal_clk_on     = cal_clk_on_q;
   assign dac_cal_start      = dac_cal_q;
   assign ramp_enable        = ramp_en_q;
   assign ramp_lower         = ramp_low_out_q;
   assign ramp_upper         = ramp_high_out_q;
   assign ramp_rise_step     = ramp_rise_out_q;
endmodule : spdr_regs

/* File: include/spdr_pkg.sv */
package spdr_pkg;
   // Register indices; the byte address is four times the index.
   localparam logic [3:0]  IDX_FIRST_CTRL  = 4'h0;
   localparam logic [3:0]  IDX_SECOND_CTRL = 4'h1;
   localparam logic [3:0]  IDX_CLK_MULT    = 4'h2;
   localparam logic [3:0]  IDX_DAC_CAL     = 4'h3;
   localparam logic [3:0]  IDX_RAMP_LOW    = 4'h4;
   localparam logic [3:0]  IDX_RAMP_HIGH   = 4'h5;
   localparam logic [3:0]  IDX_RAMP_RISE   = 4'h6;
   localparam int          IDX_LSB         = 2;
   localparam int          IDX_MSB         = 5;
   localparam int          ADDR_W          = 8;

   // First and second control words (only the bits this block owns).
   localparam int          FC_OSC_CAL_BIT  = 24;
   localparam int          FC_LOCK_BIT     = 24;
   localparam int          SC_RAMP_EN_BIT  = 19;

   // Clock multiplier control word.
   localparam int          CM_DBL_EN_BIT   = 19;
   localparam int          CM_DBL_EDGE_BIT = 16;
   localparam int          CM_N_LSB        = 8;
   localparam int          CM_N_MSB        = 15;
   localparam int          CM_MAN_PUMP_BIT = 6;
   localparam int          CM_PUMP_LSB     = 3;
   localparam int          CM_PUMP_MSB     = 5;
   localparam int          CM_LOCK_EN_BIT  = 2;
   localparam int          CM_WIN_LSB      = 0;
   localparam int          CM_WIN_MSB      = 1;
   localparam logic [7:0]  CM_N_RESET      = 8'h19;

   // DAC calibration control word.
   localparam int          DC_SYNC_PD_BIT  = 26;
   localparam int          DC_CLK_PD_BIT   = 25;
   localparam int          DC_CAL_GO_BIT   = 24;
   localparam int          DC_KEEP_MSB     = 23;
   localparam logic [23:0] DC_KEEP_RESET   = 24'h000000;

   // Lock window: 128 reference cycles shifted left by the 2-bit code.
   localparam logic [10:0] LOCK_WIN_BASE   = 11'h080;
   localparam int          LOCK_CNT_W      = 11;

   typedef enum logic [2:0] {
      LD_OFF    = 3'b001,
      LD_SEEK   = 3'b010,
      LD_LOCKED = 3'b100
   } spdr_lock_state_t;
endpackage : spdr_pkg

/* File: tb/spdr_loop_model.sv */
`timescale 1ns/1ps
module spdr_loop_model (
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // Bench control
   input  wire logic in_window,
   // Loop observation
   output logic      ref_tick,
   output logic      phase_in_window,
   output int        tick_cnt
);
   logic [2:0] div_q;
   // Ticks eight clocks apart leave room to sample the lock flag between them.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q <= 3'h0;
         tick_cnt <= 0;
      end else begin
         div_q <= div_q + 3'h1;
         if (ref_tick) tick_cnt <= in_window ? tick_cnt + 1 : 0;
      end
   end
   assign ref_tick = (div_q == 3'h7);
   assign phase_in_window = in_window;
endmodule : spdr_loop_model

/* File: tb/spdr_regs_props.sv */
`timescale 1ns/1ps
module spdr_regs_chk
   import spdr_pkg::*;
(
   // Clock, reset and bus
   input wire logic              pclk,
   input wire logic              presetn,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0]       pwdata,
   input wire logic              pready,
   input wire logic [31:0]       prdata,
   input wire logic              pslverr,
   // Loop, DAC and ramp
   input wire logic              ref_tick,
   input wire logic              phase_in_window,
   input wire logic [7:0]        feedback_div_n,
   input wire logic [8:0]        loop_mult_total,
   input wire logic              lock_detect_en,
   input wire logic              pll_locked,
   input wire logic              osc_cal_start,
   input wire logic              sync_out_pd,
   input wire logic              dac_cal_clk_on,
   input wire logic              dac_cal_start,
   input wire logic              ramp_enable,
   input wire logic [31:0]       ramp_lower,
   input wire logic [31:0]       ramp_upper
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   AST_PREADY_ACCESS: assert property (psel && !penable |=> pready)
      else $error("no answer in the access cycle");
   AST_ERR_UNMAPPED: assert property (pready && (paddr[1:0] != 2'h0 || paddr > 8'h18)
      |-> pslverr && prdata == 32'h0) else $error("unmapped access not refused");
   AST_IDLE_ZERO: assert property (!pready |-> prdata == 32'h0 && !pslverr)
      else $error("read data outside access");
   AST_MULT_TWICE: assert property ($past(presetn, 2) && $stable(feedback_div_n)
      && feedback_div_n == $past(feedback_div_n, 2) |-> loop_mult_total == {feedback_div_n, 1'b0})
      else $error("total multiplication not twice the divider");
   AST_CAL_CLK: assert property (sync_out_pd |-> !dac_cal_clk_on)
      else $error("calibration clock runs with sync powered down");
   AST_DAC_CAL_GO: assert property (pready && pwrite && paddr == 8'h0C && pwdata[24]
      |-> ##[1:2] dac_cal_start) else $error("DAC calibration not started");
   AST_DAC_CAL_PULSE: assert property (dac_cal_start |=> !dac_cal_start)
      else $error("DAC calibration start too long");
   AST_OSC_CAL_GO: assert property (pready && pwrite && paddr == 8'h00 && pwdata[24]
      |-> ##[1:2] osc_cal_start) else $error("oscillator calibration not started");
   AST_RAMP_OFF: assert property (!ramp_enable && !$past(ramp_enable)
      |-> ramp_lower == 32'h0 && ramp_upper == 32'h0) else $error("ramp live while off");
   AST_LOCK_LOSS: assert property (ref_tick && !phase_in_window |-> ##[1:3] !pll_locked)
      else $error("lock held after phase error");
   AST_LOCK_OFF: assert property ($fell(lock_detect_en) |-> ##[0:3] !pll_locked)
      else $error("lock held after detection disabled");
   COV_LOCK: cover property ($rose(pll_locked));
endmodule : spdr_regs_chk

bind spdr_regs spdr_regs_chk spdr_regs_chk_i (.*);

/* File: tb/tb_synth_pll_dac_ramp_registers.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin errors++; \
   $display("[ERR] %s exp %0h got %0h", nm, ex, gt); end end
module tb_synth_pll_dac_ramp_registers;
   import spdr_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, ramp_lower, ramp_upper, ramp_rise_step, w, v[3];
   logic in_window = 1'b0, pready, pslverr, ref_tick, phase_in_window, doubler_on;
   logic lock_detect_en, pll_locked, osc_cal_start, sync_out_pd, dac_cal_clk_on;
   logic dac_cal_start, ramp_enable;
   logic [2:0] auto_pump_code = 3'h0, pump_current_code;
   logic [7:0] feedback_div_n, n, bad[4] = '{8'h1C, 8'h05, 8'h80, 8'hFE};
   logic [8:0] loop_mult_total;
   logic [1:0] lock_window_length;
   logic [33:0] expq[$], e;
   int tick_cnt, errors = 0, checked = 0, cal_cnt = 0, osc_cnt = 0;
   int seed = 32'h2f85f22d;

   spdr_regs spdr_regs_i (.*);
   spdr_loop_model spdr_loop_model_i (.pclk(pclk), .presetn(presetn), .in_window(in_window),
      .ref_tick(ref_tick), .phase_in_window(phase_in_window), .tick_cnt(tick_cnt));

   initial forever #2.5 pclk = ~pclk;

   always @(posedge pclk) begin
      if (dac_cal_start === 1'b1) cal_cnt++;
      if (osc_cal_start === 1'b1) osc_cnt++;
      if (psel && penable && pready === 1'b1) begin
         e = expq.pop_front();
         `CHK("pslverr", e[32], pslverr)
         if (e[33]) `CHK("prdata", e[31:0], prdata)
      end
   end

   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic er, input logic [31:0] ex);
      expq.push_back({!wr, er, ex});
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : xfer

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d, 1'b0, 32'h0);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] ex);
      xfer(1'b0, a, 32'h0, 1'b0, ex);
   endtask : rd

   task automatic summarize;
      if (errors == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : summarize

   // The lock sweep dominates the run at about sixteen thousand cycles.
   initial begin
      repeat (40000) @(posedge pclk);
      errors++;
      summarize();
   end

   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      `CHK("div_rst", 8'h19, feedback_div_n)
      `CHK("mult_rst", 9'h032, loop_mult_total)
      rd(8'h08, 32'h0000_1900);
      rd(8'h0C, {8'h00, DC_KEEP_RESET});
      wr(8'h00, 32'hFFFF_FFFF);
      rd(8'h00, 32'h0);
      `CHK("osc_cal", 1, osc_cnt)
      for (int i = 0; i < 4; i++) begin
         w = $random(seed);
         n = 8'(10 + {$random(seed)} % 246);
         w[15:8] = n;
         w[1:0] = i[1:0];
         auto_pump_code <= 3'($random(seed));
         wr(8'h08, w);
         repeat (2) @(posedge pclk);
         `CHK("doubler", w[16] & w[19], doubler_on)
         `CHK("div_n", n, feedback_div_n)
         `CHK("mult", {n, 1'b0}, loop_mult_total)
         `CHK("pump", w[6] ? w[5:3] : auto_pump_code, pump_current_code)
         `CHK("lock_en", w[2], lock_detect_en)
         `CHK("window", w[1:0], lock_window_length)
         rd(8'h08, w & 32'h0009_FF7F);
      end
      for (int c = 0; c < 4; c++) begin
         wr(8'h08, 32'h0000_1904 | 32'(c));
         repeat (10) @(posedge pclk);
         in_window <= 1'b1;
         while (tick_cnt != (128 << c) - 1) @(posedge pclk);
         repeat (4) @(posedge pclk);
         `CHK("early", 1'b0, pll_locked)
         while (tick_cnt != 128 << c) @(posedge pclk);
         repeat (4) @(posedge pclk);
         `CHK("locked", 1'b1, pll_locked)
         rd(8'h00, 32'h0100_0000);
         if (c == 3) wr(8'h08, 32'h0000_1900);
         in_window <= 1'b0;
         repeat (12) @(posedge pclk);
         `CHK("lost", 1'b0, pll_locked)
      end
      for (int j = 0; j < 4; j++) begin
         w = {5'h00, j[1:0], 1'b1, DC_KEEP_RESET};
         wr(8'h0C, w);
         repeat (2) @(posedge pclk);
         `CHK("sync_pd", w[26], sync_out_pd)
         `CHK("cal_clk", !(w[26] | w[25]), dac_cal_clk_on)
         `CHK("dac_cal", j + 1, cal_cnt)
         rd(8'h0C, w & 32'h06FF_FFFF);
      end
      wr(8'h0C, {8'h00, DC_KEEP_RESET});
      repeat (2) @(posedge pclk);
      `CHK("dac_cal_idle", 4, cal_cnt)
      `CHK("cal_clk_on", 1'b1, dac_cal_clk_on)
      for (int k = 0; k < 3; k++) begin
         v[k] = $random(seed);
         wr(8'(16 + 4 * k), v[k]);
         rd(8'(16 + 4 * k), v[k]);
      end
      `CHK("ramp_off", 96'h0, {ramp_lower, ramp_upper, ramp_rise_step})
      wr(8'h04, 32'hFFFF_FFFF);
      rd(8'h04, 32'h0008_0000);
      `CHK("ramp_en", 1'b1, ramp_enable)
      `CHK("ramp_on", {v[0], v[1], v[2]}, {ramp_lower, ramp_upper, ramp_rise_step})
      wr(8'h04, 32'h0);
      rd(8'h10, v[0]);
      `CHK("ramp_idle", 32'h0, ramp_lower)
      `CHK("ramp_dis", 1'b0, ramp_enable)
      for (int m = 0; m < 4; m++) begin
         xfer(1'b1, bad[m], 32'hFFFF_FFFF, 1'b1, 32'h0);
         xfer(1'b0, bad[m], 32'h0, 1'b1, 32'h0);
      end
      rd(8'h18, v[2]);
      rd(8'h04, 32'h0);
      summarize();
   end
endmodule : tb_synth_pll_dac_ramp_registers
